// ---- rtl/rscb_top.v ----
// Receive signaling update control with APB register slave
//
// The APB slave port was chosen for this implementation.
`include "rscb_defines.vh"
`default_nettype none
// Notes on behaviour
// - Periodic mode: interrupt each E1 CAS multiframe
// - Otherwise interrupt only on stack change
// - T1 overwrite forces robbed bit 8 high
// - T1 pattern freeze blocks channel stack and buffer
// - Pattern freeze never touches pin or interrupt
// - Debounce only stack channels, compare in/out
// - Output bit follows only repeated input
// - Multiframe end copies input to output
// - No debounce: output updates with D bit
// - Manual bits drive pin, interrupt unchanged
// - Freeze assert, release clear: pin high, no updates
// - Freeze release: pin low, all updates
// - Both clear: pin follows freeze condition
// - Transparent mode follows realignment, no alarm
module rscb_top #(
  parameter [3:0] FREEZE_PATTERN = `RSCB_FREEZE_PATTERN,
  parameter [31:0] CAS_MF_CYCLES = `RSCB_CAS_MF_CYC
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SIG_VALID,
  input wire [4:0] SIG_CHAN,
  input wire [3:0] SIG_ABCD,
  input wire MF_END,
  input wire FREEZE_COND,
  input wire RX_REALIGN,
  input wire [4:0] SLIP_FRAME_OFS,
  input wire [4:0] RX_FRAME,
  input wire ROB_VALID,
  input wire [7:0] ROB_DATA,
  input wire RECEIVE_IDLE_INSERT,
  output reg [7:0] SLIP_DATA,
  output reg SLIP_VALID,
  output reg SIGNALING_FREEZE_PIN,
  output reg RX_MULTIFRAME_SYNC,
  output reg STACK_PUSH,
  output reg [4:0] STACK_CHAN,
  output reg [3:0] STACK_ABCD,
  output wire IRQ
);
  // ==========================================================
  // Registers
  reg [7:0] receive_signaling_config;
  reg [1:0] mode;
  reg [31:0] stack_channel_enable;
  reg [4:0] chan_sel;
  reg [`RSCB_ST_W-1:0] status;
  reg [`RSCB_ST_W-1:0] mask;
  reg [3:0] buf_in [0:`RSCB_NCHAN-1];
  reg [3:0] receive_signaling_buffer [0:`RSCB_NCHAN-1];
  reg [31:0] pattern_hold;
  reg [31:0] mf_count;
  reg [4:0] mf_phase;
  reg [31:0] rdata;
  integer i;

  wire wr = PSEL & PENABLE & PWRITE;
  wire rd = PSEL & ~PWRITE;
  wire cfg_trans = receive_signaling_config[`RSCB_CFG_TRANSPARENT];
  wire manual_freeze_assert = receive_signaling_config[`RSCB_CFG_FRZ_ASSERT];
  wire manual_freeze_release = receive_signaling_config[`RSCB_CFG_FRZ_RELEASE];
  wire cfg_debounce = receive_signaling_config[`RSCB_CFG_DEBOUNCE];
  wire pattern_freeze_detect = receive_signaling_config[`RSCB_CFG_PATTERN];
  wire cfg_robbed = receive_signaling_config[`RSCB_CFG_ROBBED_ONE];
  wire periodic_sig_irq_force = receive_signaling_config[`RSCB_CFG_PERIODIC];
  wire is_e1 = mode[`RSCB_MODE_E1];
  wire cas_on = mode[`RSCB_MODE_CAS];

  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA = rdata;

  // ==========================================================
  // Freeze and update gating
  // Pin: assert wins only with release clear; both clear follows condition
  wire global_freeze = manual_freeze_release ? 1'b0 :
                       manual_freeze_assert ? 1'b1 :
                       FREEZE_COND;
  wire stk_en = stack_channel_enable[SIG_CHAN];
  wire pat_hit = pattern_freeze_detect & ~is_e1 & (SIG_ABCD == FREEZE_PATTERN);
  wire chan_upd = SIG_VALID & ~global_freeze & ~pat_hit;
  wire deb_on = cfg_debounce & stk_en;
  wire [3:0] cur_in = buf_in[SIG_CHAN];
  wire [3:0] cur_out = receive_signaling_buffer[SIG_CHAN];
  wire [3:0] next_in;
  wire [3:0] next_out;

  rscb_chan_update u_upd (
    .IN_BITS(SIG_ABCD),
    .CUR_IN(cur_in),
    .CUR_OUT(cur_out),
    .DEBOUNCE_ON(deb_on),
    .NEXT_IN(next_in),
    .NEXT_OUT(next_out)
  );

  // Debounced channels store only when the buffered or the next in and out differ
  wire store_ok = ~deb_on | (next_in != next_out) | (cur_in != cur_out);
  wire changed = next_out != cur_out;
  wire push = chan_upd & store_ok & stk_en & changed;

  // ==========================================================
  // Signaling buffer and stack
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (i = 0; i < `RSCB_NCHAN; i = i + 1) begin
        buf_in[i] <= 4'h0;
        receive_signaling_buffer[i] <= 4'h0;
      end
      STACK_PUSH <= 1'b0;
      STACK_CHAN <= 5'h00;
      STACK_ABCD <= 4'h0;
      pattern_hold <= 32'h00000000;
    end else begin
      STACK_PUSH <= push;
      if (push) begin
        STACK_CHAN <= SIG_CHAN;
        STACK_ABCD <= next_out;
      end
      if (SIG_VALID) begin
        pattern_hold[SIG_CHAN] <= pat_hit;
      end
      if (chan_upd & store_ok) begin
        buf_in[SIG_CHAN] <= next_in;
        receive_signaling_buffer[SIG_CHAN] <= next_out;
      end
      if (MF_END & cfg_debounce & ~global_freeze) begin
        for (i = 0; i < `RSCB_NCHAN; i = i + 1) begin
          if (stack_channel_enable[i] & ~pattern_hold[i]) begin
            receive_signaling_buffer[i] <= buf_in[i];
          end
        end
      end
    end
  end

  // ==========================================================
  // Robbed-bit overwrite toward the slip buffer
  wire sig_frame = (RX_FRAME == 5'h05) | (RX_FRAME == 5'h0B) |
                   (RX_FRAME == 5'h11) | (RX_FRAME == 5'h17);
  wire force_one = cfg_robbed & ~is_e1 & ~RECEIVE_IDLE_INSERT & sig_frame;

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      SLIP_DATA <= 8'h00;
      SLIP_VALID <= 1'b0;
      SIGNALING_FREEZE_PIN <= 1'b0;
    end else begin
      SLIP_VALID <= ROB_VALID;
      // Bit 8 of the time slot is the LSB here
      SLIP_DATA <= {ROB_DATA[7:1], ROB_DATA[0] | force_one};
      SIGNALING_FREEZE_PIN <= global_freeze;
    end
  end

  // ==========================================================
  // Multiframe sync: transparent mode tracks receiver realignment
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      mf_phase <= 5'h00;
      RX_MULTIFRAME_SYNC <= 1'b0;
    end else begin
      if (cfg_trans & RX_REALIGN) begin
        mf_phase <= SLIP_FRAME_OFS;
      end
      // Realignment raises no alarm in transparent mode; otherwise it sets the realign status
      RX_MULTIFRAME_SYNC <= cfg_trans & ROB_VALID & (RX_FRAME == mf_phase);
    end
  end

  // ==========================================================
  // Periodic CAS timer
  wire periodic = periodic_sig_irq_force & is_e1 & cas_on;
  wire mf_tick = periodic & (mf_count == CAS_MF_CYCLES - 32'h1);
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      mf_count <= 32'h00000000;
    end else if (!periodic | mf_tick) begin
      mf_count <= 32'h00000000;
    end else begin
      mf_count <= mf_count + 32'h1;
    end
  end

  // ==========================================================
  // Interrupt status, set wins over write-one clear
  wire [`RSCB_ST_W-1:0] set_ev;
  assign set_ev[`RSCB_ST_SIG] = periodic ? mf_tick : push;
  assign set_ev[`RSCB_ST_FRZ] = FREEZE_COND;
  assign set_ev[`RSCB_ST_REALIGN] = RX_REALIGN & ~cfg_trans;
  wire [`RSCB_ST_W-1:0] clr = (wr && PADDR == `RSCB_ADDR_STATUS) ?
                              PWDATA[`RSCB_ST_W-1:0] : {`RSCB_ST_W{1'b0}};
  assign IRQ = |(status & mask);

  // ==========================================================
  // APB registers
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      receive_signaling_config <= `RSCB_CFG_RESET;
      mode <= `RSCB_MODE_RESET;
      stack_channel_enable <= 32'h00000000;
      chan_sel <= 5'h00;
      status <= {`RSCB_ST_W{1'b0}};
      mask <= {`RSCB_ST_W{1'b0}};
    end else begin
      status <= (status & ~clr) | set_ev;
      if (wr) begin
        case (PADDR)
          `RSCB_ADDR_CONFIG: receive_signaling_config <= {1'b0, PWDATA[6:0]};
          `RSCB_ADDR_MASK: mask <= PWDATA[`RSCB_ST_W-1:0];
          `RSCB_ADDR_MODE: mode <= PWDATA[1:0];
          `RSCB_ADDR_STACK_EN: stack_channel_enable <= PWDATA;
          `RSCB_ADDR_CHAN_SEL: chan_sel <= PWDATA[4:0];
          default: ;
        endcase
      end
    end
  end

  always @* begin
    rdata = 32'h00000000;
    if (rd) begin
      case (PADDR)
        `RSCB_ADDR_CONFIG: rdata = {24'h000000, receive_signaling_config};
        `RSCB_ADDR_STATUS: rdata = {29'h0, status};
        `RSCB_ADDR_MASK: rdata = {29'h0, mask};
        `RSCB_ADDR_MODE: rdata = {30'h0, mode};
        `RSCB_ADDR_STACK_EN: rdata = stack_channel_enable;
        `RSCB_ADDR_CHAN_SEL: rdata = {27'h0, chan_sel};
        `RSCB_ADDR_CHAN_READ: rdata = {24'h0, buf_in[chan_sel],
                                       receive_signaling_buffer[chan_sel]};
        default: rdata = 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- pkg/rscb_defines.vh ----
// Constants of the receive signaling update control block
`ifndef RSCB_DEFINES_VH
`define RSCB_DEFINES_VH
// Register byte addresses (config offset is a word index, byte address = 4 * index)
`define RSCB_IDX_CONFIG 8'hD7
`define RSCB_ADDR_CONFIG 12'h35C
`define RSCB_ADDR_STATUS 12'h400
`define RSCB_ADDR_MASK 12'h404
`define RSCB_ADDR_MODE 12'h408
`define RSCB_ADDR_STACK_EN 12'h40C
`define RSCB_ADDR_CHAN_SEL 12'h410
`define RSCB_ADDR_CHAN_READ 12'h414
// Config fields
`define RSCB_CFG_TRANSPARENT 0
`define RSCB_CFG_FRZ_ASSERT 1
`define RSCB_CFG_FRZ_RELEASE 2
`define RSCB_CFG_DEBOUNCE 3
`define RSCB_CFG_PATTERN 4
`define RSCB_CFG_ROBBED_ONE 5
`define RSCB_CFG_PERIODIC 6
`define RSCB_CFG_RESET 8'h00
// Mode fields
`define RSCB_MODE_E1 0
`define RSCB_MODE_CAS 1
`define RSCB_MODE_RESET 2'h0
// Status fields
`define RSCB_ST_SIG 0
`define RSCB_ST_FRZ 1
`define RSCB_ST_REALIGN 2
`define RSCB_ST_W 3
// Timing
`define RSCB_PERIOD_NS 10
`define RSCB_CAS_MF_NS 2000000
`define RSCB_CAS_MF_CYC (`RSCB_CAS_MF_NS / `RSCB_PERIOD_NS)
// Sizes
`define RSCB_NCHAN 32
`define RSCB_FREEZE_PATTERN 4'hF
`endif

// ---- rtl/rscb_chan_update.v ----
// Per-bit signaling debounce for one ABCD value
`default_nettype none
module rscb_chan_update (
  input wire [3:0] IN_BITS,
  input wire [3:0] CUR_IN,
  input wire [3:0] CUR_OUT,
  input wire DEBOUNCE_ON,
  output wire [3:0] NEXT_IN,
  output wire [3:0] NEXT_OUT
);
  // Debounced: output follows only when the new bit repeats the stored input
  assign NEXT_IN = IN_BITS;
  assign NEXT_OUT = DEBOUNCE_ON ?
    ((IN_BITS & ~(IN_BITS ^ CUR_IN)) | (CUR_OUT & (IN_BITS ^ CUR_IN))) :
    IN_BITS;
endmodule
`default_nettype wire

// ---- sim/rscb_sva.sv ----
// Checker of the receive signaling update control ports
`include "rscb_defines.vh"
`default_nettype none
module rscb_sva (
  input wire logic CLK_SYS, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic SIG_VALID, STACK_PUSH, ROB_VALID, SLIP_VALID, FREEZE_COND,
  input wire logic SIGNALING_FREEZE_PIN, RX_MULTIFRAME_SYNC,
  input wire logic [4:0] SIG_CHAN, STACK_CHAN,
  input wire logic [7:0] ROB_DATA, SLIP_DATA
);
  logic [7:0] cfg, msk;
  logic [1:0] age;
  wire wr = PSEL & PENABLE & PWRITE;
  // ==========================================
  // Shadows: properties wait until a write has settled
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cfg <= 8'h00;
      msk <= 8'h00;
      age <= 2'h0;
    end else begin
      if (wr && PADDR == `RSCB_ADDR_CONFIG) cfg <= PWDATA[7:0];
      if (wr && PADDR == `RSCB_ADDR_MASK) msk <= PWDATA[7:0];
      age <= wr ? 2'h0 : age + {1'b0, age != 2'h3};
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  a_apb_ready: assert property (PREADY && !PSLVERR) else $error("apb stall or error");
  a_pin_release: assert property (age == 2'h3 && cfg[2] |-> !SIGNALING_FREEZE_PIN)
    else $error("pin high under release");
  a_pin_assert: assert property (age == 2'h3 && cfg[2:1] == 2'b01 |-> SIGNALING_FREEZE_PIN)
    else $error("pin low under assert");
  a_pin_follows: assert property (age == 2'h3 && cfg[2:1] == 2'b00 && $stable(FREEZE_COND)
    |-> SIGNALING_FREEZE_PIN == FREEZE_COND) else $error("pin not following condition");
  a_push_frozen: assert property (SIG_VALID && age == 2'h3 && cfg[2:1] == 2'b01
    |=> !STACK_PUSH) else $error("push while frozen");
  a_push_source: assert property (STACK_PUSH |-> $past(SIG_VALID) && STACK_CHAN == $past(SIG_CHAN))
    else $error("push without update");
  a_slip_pulse: assert property (SLIP_VALID == $past(ROB_VALID)) else $error("slip timing");
  a_slip_plain: assert property (SLIP_VALID && !cfg[5] && age == 2'h3
    |-> SLIP_DATA == $past(ROB_DATA)) else $error("slip data altered");
  a_irq_masked: assert property (msk == 8'h00 && age == 2'h3 |-> !IRQ)
    else $error("irq while masked");
  a_sync_gate: assert property (RX_MULTIFRAME_SYNC && age == 2'h3 |-> cfg[0] && $past(ROB_VALID))
    else $error("sync outside transparent mode");
  c_push: cover property (STACK_PUSH);
  c_irq: cover property (IRQ);
  c_robbed: cover property (SLIP_VALID && cfg[5]);
endmodule
bind rscb_top rscb_sva i_sva (.*);
`default_nettype wire

// ---- sim/receive_signaling_control_test.sv ----
// Self-checking bench of the receive signaling update control
`include "rscb_defines.vh"
`default_nettype none
module receive_signaling_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MF = 20;
  localparam logic [11:0] CFG = `RSCB_ADDR_CONFIG;
  localparam logic [11:0] ST = `RSCB_ADDR_STATUS;
  logic CLK_SYS = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic SIG_VALID = 1'b0, FREEZE_COND = 1'b0, ROB_VALID = 1'b0;
  logic MF_END = 1'b0, RX_REALIGN = 1'b0, RECEIVE_IDLE_INSERT = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, q;
  logic [4:0] SIG_CHAN = 5'h00, RX_FRAME = 5'h00, SLIP_FRAME_OFS = 5'h00, c;
  logic [3:0] SIG_ABCD = 4'h0, v;
  logic [7:0] ROB_DATA = 8'h00, d;
  logic [7:0] frz [4] = '{8'h04, 8'h02, 8'h00, 8'h06};
  wire [31:0] PRDATA;
  wire [7:0] SLIP_DATA;
  wire [4:0] STACK_CHAN;
  wire [3:0] STACK_ABCD;
  wire PREADY, PSLVERR, SLIP_VALID, SIGNALING_FREEZE_PIN, RX_MULTIFRAME_SYNC, STACK_PUSH, IRQ;
  int seed = 32'h820F, n_mismatch = 0, comparisons = 0, cnt;
  time t1, t2;
  rscb_top #(.CAS_MF_CYCLES(MF)) i_dut (.*);
  // ==========================================
  // Helpers
  function automatic logic exp_pin(logic [7:0] f, logic cond);
    return f[2] ? 1'b0 : (f[1] | cond);
  endfunction
  function automatic logic [7:0] exp_rob(logic [7:0] f, logic [4:0] fr, logic [7:0] dd,
                                         logic idle);
    return (f[5] && !idle && fr % 6 == 5) ? (dd | 8'h01) : dd;
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] dd);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= dd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge CLK_SYS);
      if (PREADY === 1'b1) break;
      if (k == 49) n_mismatch++;
      if (k == 49) give_verdict;
    end
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge keeps the next setup from reassigning PSEL in this step
    @(posedge CLK_SYS);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] dd);
    apb(1'b1, a, dd);
  endtask
  task automatic rd_chk(logic [11:0] a, logic [31:0] m, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q & m, exp);
  endtask
  // Push is registered on the taking edge and checked just after it
  task automatic sig(logic [4:0] ch, logic [3:0] val, logic p, logic chk);
    SIG_VALID <= 1'b1;
    SIG_CHAN <= ch;
    SIG_ABCD <= val;
    @(posedge CLK_SYS);
    SIG_VALID <= 1'b0;
    #1;
    if (chk) check(STACK_PUSH, p);
    if (chk && p) check(STACK_ABCD, val);
    if (chk && p) check(STACK_CHAN, ch);
    @(posedge CLK_SYS);
  endtask
  task automatic wait_irq(output time t);
    for (int k = 0; IRQ !== 1'b1; k++) begin
      if (k > 100) n_mismatch++;
      if (k > 100) give_verdict;
      @(posedge CLK_SYS);
      #1;
    end
    t = $time;
  endtask
  // ==========================================
  // Sequence
  initial forever #5 CLK_SYS = ~CLK_SYS;
  initial begin
    #400000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
    rd_chk(CFG, 32'hFF, 32'h0);
    d = $random(seed) & 8'h7F;
    wr(CFG, d);
    rd_chk(CFG, 32'hFF, d);
    wr(12'h7F0, 32'hFFFFFFFF);
    rd_chk(12'h7F0, 32'hFFFFFFFF, 32'h0);
    wr(`RSCB_ADDR_STACK_EN, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      c = $random(seed);
      v = $random(seed);
      FREEZE_COND <= 1'b0;
      wr(CFG, 32'h04);
      sig(c, v, 1'b1, 1'b0);
      FREEZE_COND <= i[0];
      wr(CFG, frz[i / 2]);
      repeat (2) @(posedge CLK_SYS);
      #1 check(SIGNALING_FREEZE_PIN, exp_pin(frz[i / 2], i[0]));
      if (i[0]) rd_chk(ST, 32'h2, 32'h2);
      sig(c, ~v, !exp_pin(frz[i / 2], i[0]), 1'b1);
      wr(ST, 32'h7);
    end
    FREEZE_COND <= 1'b0;
    wr(CFG, 32'h04);
    sig(5'h07, 4'h0, 1'b0, 1'b0);
    wr(CFG, 32'h0C);
    sig(5'h07, 4'h3, 1'b0, 1'b1);
    sig(5'h07, 4'h3, 1'b1, 1'b1);
    wr(`RSCB_ADDR_CHAN_SEL, 32'h7);
    rd_chk(`RSCB_ADDR_CHAN_READ, 32'hFF, 32'h33);
    sig(5'h07, 4'hC, 1'b0, 1'b1);
    MF_END <= 1'b1;
    @(posedge CLK_SYS);
    MF_END <= 1'b0;
    rd_chk(`RSCB_ADDR_CHAN_READ, 32'hFF, 32'hCC);
    wr(CFG, 32'h00);
    sig(5'h03, 4'h5, 1'b1, 1'b0);
    wr(CFG, 32'h10);
    wr(ST, 32'h7);
    sig(5'h03, `RSCB_FREEZE_PATTERN, 1'b0, 1'b1);
    check(SIGNALING_FREEZE_PIN, 1'b0);
    rd_chk(ST, 32'h3, 32'h0);
    wr(CFG, 32'h00);
    sig(5'h03, `RSCB_FREEZE_PATTERN, 1'b1, 1'b1);
    wr(`RSCB_ADDR_MASK, 32'h1);
    #1 check(IRQ, 1'b1);
    wr(`RSCB_ADDR_MASK, 32'h0);
    #1 check(IRQ, 1'b0);
    wr(ST, 32'h7);
    wr(`RSCB_ADDR_MASK, 32'h1);
    repeat (3 * MF) @(posedge CLK_SYS);
    #1 check(IRQ, 1'b0);
    wr(`RSCB_ADDR_MODE, 32'h3);
    wr(CFG, 32'h40);
    wait_irq(t1);
    wr(ST, 32'h1);
    #1 wait_irq(t2);
    check(32'((t2 - t1) / 10), MF);
    wr(`RSCB_ADDR_MODE, 32'h0);
    for (int pass = 0; pass < 2; pass++) begin
      wr(CFG, pass ? 32'h01 : 32'h20);
      wr(ST, 32'h7);
      SLIP_FRAME_OFS <= 5'h03;
      RX_REALIGN <= 1'b1;
      @(posedge CLK_SYS);
      RX_REALIGN <= 1'b0;
      cnt = 0;
      for (int f = 0; f < 24; f++) begin
        d = $random(seed);
        ROB_VALID <= 1'b1;
        ROB_DATA <= d;
        RX_FRAME <= f[4:0];
        RECEIVE_IDLE_INSERT <= d[6];
        @(posedge CLK_SYS);
        ROB_VALID <= 1'b0;
        #1 check(SLIP_DATA, exp_rob(pass ? 8'h01 : 8'h20, f[4:0], d, d[6]));
        cnt += RX_MULTIFRAME_SYNC;
      end
      check(cnt, pass);
      rd_chk(ST, 32'h4, pass ? 32'h0 : 32'h4);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
